// ==== design/sfw_pkg.sv ====
// Shared constants and types of the flash program, erase and wrap sequencer
package sfw_pkg;
    // Command codes
    localparam logic [7:0] OPC_WRAP_SET = 8'h77;
    localparam logic [7:0] OPC_PROG = 8'h02;
    localparam logic [7:0] OPC_QPROG = 8'h32;
    localparam logic [7:0] OPC_SECT = 8'h20;
    localparam logic [7:0] OPC_BLK32 = 8'h52;
    localparam logic [7:0] OPC_BLK64 = 8'hD8;
    localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OPC_STAT_LO = 8'h05;
    localparam logic [7:0] OPC_STAT_HI = 8'h35;
    localparam logic [7:0] OPC_RD = 8'h03;
    localparam logic [7:0] OPC_RD_FAST = 8'h0B;
    localparam logic [7:0] OPC_RD_DUAL = 8'h3B;
    localparam logic [7:0] OPC_RD_QUAD = 8'h6B;
    localparam logic [7:0] OPC_RD_DIO = 8'hBB;
    localparam logic [7:0] OPC_RD_QIO = 8'hEB;
    // Frame layout
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [1:0] DUMMY_BYTES = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] STEP_SINGLE = 4'h1;
    localparam logic [3:0] STEP_QUAD = 4'h4;
    // Wrap byte fields and reset values
    localparam int WRAP_DIS_POS = 4;
    localparam int WRAP_LEN_LSB = 5;
    localparam logic WRAP_DIS_RST = 1'b1;
    localparam logic [1:0] WRAP_LEN_RST = 2'h0;
    localparam logic [8:0] WRAP_MIN_SPAN = 9'h008;
    // Geometry of the 8 Mbit array
    localparam int PAGE_BITS = 8;
    localparam int SECT_BITS = 12;
    localparam int BLK32_BITS = 15;
    localparam int BLK64_BITS = 16;
    localparam logic [20:0] ARRAY_SIZE = 21'h10_0000;
    localparam logic [20:0] ZONE_UNIT_BIG = 21'h01_0000;
    localparam logic [20:0] ZONE_UNIT_SMALL = 21'h00_1000;
    localparam logic [20:0] ZONE_SMALL_MAX = 21'h00_8000;
    // Self-timed durations, microseconds, and clock rate
    localparam int CLK_MHZ = 40;
    localparam int PROG_TIME_US = 700;
    localparam int SECT_TIME_US = 50000;
    localparam int BLK32_TIME_US = 150000;
    localparam int BLK64_TIME_US = 200000;
    localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
    localparam int SECT_CYC = SECT_TIME_US * CLK_MHZ;
    localparam int BLK32_CYC = BLK32_TIME_US * CLK_MHZ;
    localparam int BLK64_CYC = BLK64_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 24;
    // Command sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_DUMMY = 7'b000_0100,
        ST_WRAP = 7'b000_1000,
        ST_DATA = 7'b001_0000,
        ST_HOLD = 7'b010_0000,
        ST_SKIP = 7'b100_0000
    } sfw_state_e;
    typedef enum logic [2:0] {
        OP_PROG = 3'h0,
        OP_SECT = 3'h1,
        OP_BLK32 = 3'h2,
        OP_BLK64 = 3'h3,
        OP_WRAP = 3'h4
    } sfw_op_e;
    typedef struct packed {
        sfw_op_e kind;
        logic [23:0] addr;
    } sfw_op_s;
endpackage : sfw_pkg

// ==== design/sfw_sequencer.sv ====
// Flash command sequencer: wrap setting, page program and erase cycles
`timescale 1ns/1ps
module sfw_sequencer
    import sfw_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC,
    parameter int SECT_CYCLES = SECT_CYC,
    parameter int BLK32_CYCLES = BLK32_CYC,
    parameter int BLK64_CYCLES = BLK64_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clock,
    input wire logic select_n,
    input wire logic [3:0] data_line_in,
    input wire logic quad_enable_bit,
    input wire logic [4:0] block_protect_bits,
    input wire logic [7:0] buf_rd_idx,
    input wire logic rd_load,
    input wire logic rd_advance,
    input wire logic [23:0] rd_start_addr,
    output logic write_enable_latch,
    output logic write_in_progress,
    output logic wrap_disable_bit,
    output logic [1:0] wrap_length_field,
    output logic op_start,
    output logic op_done,
    output sfw_op_s op_info,
    output logic [7:0] buf_rd_byte,
    output logic buf_rd_valid,
    output logic status_read,
    output logic read_reject,
    output logic [23:0] rd_addr
);
    sfw_state_e state_ff;
    sfw_op_s cmd_ff;
    logic sclk_ff, sel_n_ff, quad_ff, data_seen_ff;
    logic [3:0] bitpos_ff;
    logic [7:0] shreg_ff, wr_idx_ff;
    logic [1:0] cnt_ff;
    logic [7:0] page_mem [256];
    logic [255:0] mask_ff;
    logic wel_ff, busy_ff, start_ff, done_ff, stat_ff, rej_ff;
    logic wrap_dis_ff;
    logic [1:0] wrap_len_ff;
    logic [TIMER_W-1:0] timer_ff;
    logic [7:0] rbyte_ff;
    logic rvalid_ff;
    logic [23:0] rd_addr_ff;

    // True when an address lies in the zone the protect bits cover
    function automatic logic in_zone(input logic [19:0] a,
                                     input logic [4:0] bp);
        logic [20:0] sz;
        sz = bp[4] ? (ZONE_UNIT_SMALL << (bp[2:0] - 3'h1))
                   : (ZONE_UNIT_BIG << (bp[2:0] - 3'h1));
        if (bp[4] && sz > ZONE_SMALL_MAX) begin
            sz = ZONE_SMALL_MAX;
        end
        if (sz > ARRAY_SIZE) begin
            sz = ARRAY_SIZE;
        end
        if (bp[2:0] == 3'h0) begin
            in_zone = 1'b0;
        end else if (bp[3]) begin
            in_zone = {1'b0, a} < sz;
        end else begin
            in_zone = {1'b0, a} >= (ARRAY_SIZE - sz);
        end
    endfunction : in_zone

    // Region is aligned, so its two ends cover any aligned zone overlap
    function automatic logic region_locked(input sfw_op_s op,
                                           input logic [4:0] bp);
        logic [19:0] lo, hi;
        unique case (op.kind)
            OP_SECT: hi = 20'h0_0FFF;
            OP_BLK32: hi = 20'h0_7FFF;
            OP_BLK64: hi = 20'h0_FFFF;
            default: hi = 20'h0_00FF;
        endcase
        lo = op.addr[19:0] & ~hi;
        hi = lo | hi;
        region_locked = in_zone(lo, bp) || in_zone(hi, bp);
    endfunction : region_locked

    logic sclk_rise, sel_rise, byte_done, exec_ok;
    logic [3:0] pos_nxt;
    logic [7:0] nxt_byte;
    assign sclk_rise = serial_clock && !sclk_ff && !select_n;
    assign sel_rise = select_n && !sel_n_ff;
    assign pos_nxt = bitpos_ff + (quad_ff ? STEP_QUAD : STEP_SINGLE);
    assign byte_done = sclk_rise && (pos_nxt == BITS_PER_BYTE);
    assign nxt_byte = quad_ff ? {shreg_ff[3:0], data_line_in}
                              : {shreg_ff[6:0], data_line_in[0]};
    // Frame must end exactly on a byte edge of the last field
    assign exec_ok = sel_rise && ((state_ff == ST_HOLD) ||
        (state_ff == ST_DATA && bitpos_ff == 4'h0 && data_seen_ff));

    // Edge history of the serial pins
    always_ff @(posedge clock) begin
        if (reset) begin
            sclk_ff <= 1'b0;
            sel_n_ff <= 1'b1;
        end else begin
            sclk_ff <= serial_clock;
            sel_n_ff <= select_n;
        end
    end

    // Bit assembly; quad program moves four bits per edge
    always_ff @(posedge clock) begin
        if (reset || select_n) begin
            bitpos_ff <= 4'h0;
            shreg_ff <= 8'h00;
        end else if (sclk_rise) begin
            bitpos_ff <= byte_done ? 4'h0 : pos_nxt;
            shreg_ff <= nxt_byte;
        end
    end

    // Command decode and frame tracking
    always_ff @(posedge clock) begin
        if (reset || select_n) begin
            state_ff <= ST_IDLE;
            quad_ff <= 1'b0;
            cnt_ff <= 2'h0;
            if (reset) begin
                cmd_ff <= '{kind: OP_PROG, addr: 24'h00_0000};
            end
        end else if (state_ff == ST_HOLD && sclk_rise) begin
            state_ff <= ST_SKIP;
        end else if (byte_done) begin
            unique case (state_ff)
                ST_IDLE: begin
                    state_ff <= ST_SKIP;
                    cnt_ff <= 2'h0;
                    if (!busy_ff && nxt_byte == OPC_WRAP_SET) begin
                        state_ff <= ST_DUMMY;
                        cmd_ff.kind <= OP_WRAP;
                    end else if (!busy_ff && wel_ff) begin
                        state_ff <= ST_ADDR;
                        if (nxt_byte == OPC_PROG) begin
                            cmd_ff.kind <= OP_PROG;
                        end else if (nxt_byte == OPC_QPROG) begin
                            cmd_ff.kind <= OP_PROG;
                            quad_ff <= 1'b1;
                            if (!quad_enable_bit) begin
                                state_ff <= ST_SKIP;
                            end
                        end else if (nxt_byte == OPC_SECT) begin
                            cmd_ff.kind <= OP_SECT;
                        end else if (nxt_byte == OPC_BLK32) begin
                            cmd_ff.kind <= OP_BLK32;
                        end else if (nxt_byte == OPC_BLK64) begin
                            cmd_ff.kind <= OP_BLK64;
                        end else begin
                            state_ff <= ST_SKIP;
                        end
                    end
                end
                ST_ADDR: begin
                    cmd_ff.addr <= {cmd_ff.addr[15:0], nxt_byte};
                    cnt_ff <= cnt_ff + 2'h1;
                    if (cnt_ff == ADDR_BYTES - 2'h1) begin
                        state_ff <= (cmd_ff.kind == OP_PROG) ? ST_DATA
                                                             : ST_HOLD;
                    end
                end
                ST_DUMMY: begin
                    cnt_ff <= cnt_ff + 2'h1;
                    if (cnt_ff == DUMMY_BYTES - 2'h1) begin
                        state_ff <= ST_WRAP;
                    end
                end
                ST_WRAP: begin
                    cmd_ff.addr <= {16'h0000, nxt_byte};
                    state_ff <= ST_HOLD;
                end
                ST_DATA, ST_SKIP: state_ff <= state_ff;
                default: state_ff <= ST_SKIP;
            endcase
        end
    end

    // Page buffer: index wraps in the page, later bytes overwrite earlier
    always_ff @(posedge clock) begin
        if (reset) begin
            mask_ff <= '0;
            wr_idx_ff <= 8'h00;
            data_seen_ff <= 1'b0;
        end else if (byte_done && state_ff == ST_ADDR
                     && cnt_ff == ADDR_BYTES - 2'h1) begin
            mask_ff <= '0;
            wr_idx_ff <= nxt_byte;
            data_seen_ff <= 1'b0;
        end else if (byte_done && state_ff == ST_DATA) begin
            page_mem[wr_idx_ff] <= nxt_byte;
            mask_ff[wr_idx_ff] <= 1'b1;
            wr_idx_ff <= wr_idx_ff + 8'h01;
            data_seen_ff <= 1'b1;
        end
    end

    // Status and read opcodes; status stays readable while busy
    always_ff @(posedge clock) begin
        if (reset) begin
            stat_ff <= 1'b0;
            rej_ff <= 1'b0;
        end else begin
            stat_ff <= byte_done && state_ff == ST_IDLE &&
                (nxt_byte == OPC_STAT_LO || nxt_byte == OPC_STAT_HI);
            rej_ff <= byte_done && state_ff == ST_IDLE && busy_ff &&
                (nxt_byte == OPC_RD || nxt_byte == OPC_RD_FAST ||
                 nxt_byte == OPC_RD_DUAL || nxt_byte == OPC_RD_QUAD ||
                 nxt_byte == OPC_RD_DIO || nxt_byte == OPC_RD_QIO);
        end
    end

    // Write enable latch; set wins only when no cycle starts
    always_ff @(posedge clock) begin
        if (reset) begin
            wel_ff <= 1'b0;
        end else if (exec_ok && cmd_ff.kind != OP_WRAP
                     && !region_locked(cmd_ff, block_protect_bits)) begin
            wel_ff <= 1'b0;
        end else if (byte_done && state_ff == ST_IDLE && !busy_ff
                     && nxt_byte == OPC_WRITE_ENABLE_CMD) begin
            wel_ff <= 1'b1;
        end
    end

    // Wrap settings held until the next complete wrap command sent while not busy
    always_ff @(posedge clock) begin
        if (reset) begin
            wrap_dis_ff <= WRAP_DIS_RST;
            wrap_len_ff <= WRAP_LEN_RST;
        end else if (exec_ok && cmd_ff.kind == OP_WRAP) begin
            wrap_dis_ff <= cmd_ff.addr[WRAP_DIS_POS];
            wrap_len_ff <= cmd_ff.addr[WRAP_LEN_LSB +: 2];
        end
    end

    // Self-timed cycle timer; protected targets never start
    always_ff @(posedge clock) begin
        if (reset) begin
            busy_ff <= 1'b0;
            start_ff <= 1'b0;
            done_ff <= 1'b0;
            timer_ff <= '0;
        end else begin
            start_ff <= 1'b0;
            done_ff <= 1'b0;
            if (exec_ok && cmd_ff.kind != OP_WRAP
                && !region_locked(cmd_ff, block_protect_bits)) begin
                busy_ff <= 1'b1;
                start_ff <= 1'b1;
                unique case (cmd_ff.kind)
                    OP_SECT: timer_ff <= TIMER_W'(SECT_CYCLES - 1);
                    OP_BLK32: timer_ff <= TIMER_W'(BLK32_CYCLES - 1);
                    OP_BLK64: timer_ff <= TIMER_W'(BLK64_CYCLES - 1);
                    default: timer_ff <= TIMER_W'(PROG_CYCLES - 1);
                endcase
            end else if (busy_ff && timer_ff == '0) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end else if (busy_ff) begin
                timer_ff <= timer_ff - 1'b1;
            end
        end
    end

    // Buffer read port for the array engine, one cycle latency
    always_ff @(posedge clock) begin
        if (reset) begin
            rbyte_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rbyte_ff <= page_mem[buf_rd_idx];
            rvalid_ff <= mask_ff[buf_rd_idx];
        end
    end

    // Quad read address stepping; wrap keeps upper bits fixed
    logic [7:0] span_m1;
    assign span_m1 = 8'((WRAP_MIN_SPAN << wrap_len_ff) - 9'h001);
    always_ff @(posedge clock) begin
        if (reset) begin
            rd_addr_ff <= 24'h00_0000;
        end else if (rd_load) begin
            rd_addr_ff <= rd_start_addr;
        end else if (rd_advance && !wrap_dis_ff) begin
            rd_addr_ff <= (rd_addr_ff & ~{16'h0000, span_m1})
                | ((rd_addr_ff + 24'h00_0001) & {16'h0000, span_m1});
        end else if (rd_advance) begin
            rd_addr_ff <= rd_addr_ff + 24'h00_0001;
        end
    end

    assign write_enable_latch = wel_ff;
    assign write_in_progress = busy_ff;
    assign wrap_disable_bit = wrap_dis_ff;
    assign wrap_length_field = wrap_len_ff;
    assign op_start = start_ff;
    assign op_done = done_ff;
    assign op_info = cmd_ff;
    assign buf_rd_byte = rbyte_ff;
    assign buf_rd_valid = rvalid_ff;
    assign status_read = stat_ff;
    assign read_reject = rej_ff;
    assign rd_addr = rd_addr_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_START_NEEDS_WEL: assert property (op_start |-> $past(wel_ff))
        else $error("cycle started without write enable latch");
    AST_WEL_CLEARED: assert property (op_start |-> !wel_ff ##1 !wel_ff)
        else $error("write enable latch still set after start");
    AST_BUSY_HOLDS: assert property (op_start |-> write_in_progress [*8])
        else $error("busy bit dropped early");
    AST_START_AT_RISE: assert property (op_start |-> $past(sel_rise))
        else $error("cycle started without select rising");
    AST_NO_NEST: assert property (op_start |-> !$past(busy_ff, 2))
        else $error("command accepted during a running cycle");
    AST_PROT_OK: assert property (op_start
        |-> !region_locked(op_info, $past(block_protect_bits)))
        else $error("protected region was started");
    AST_WRAP_STABLE: assert property (!$past(exec_ok)
        |-> $stable(wrap_length_field) && $stable(wrap_disable_bit))
        else $error("wrap bits changed without a wrap command");
    AST_REJECT_BUSY: assert property (read_reject |-> write_in_progress
        && $stable(timer_ff) == 1'b0)
        else $error("read reject outside cycle or timer disturbed");
    AST_WRAP_SECTION: assert property (rd_advance && !rd_load
        && !wrap_disable_bit |=> rd_addr[23:6] == $past(rd_addr[23:6]))
        else $error("wrapped read left its section");
    AST_QUAD_QE: assert property (byte_done && state_ff == ST_IDLE
        && nxt_byte == OPC_QPROG && !quad_enable_bit
        |=> state_ff == ST_SKIP)
        else $error("quad program taken without quad enable");

    COV_PROG: cover property (op_start && op_info.kind == OP_PROG);
    COV_ERASE64: cover property (op_start && op_info.kind == OP_BLK64);
    COV_WRAP_SET: cover property (exec_ok && cmd_ff.kind == OP_WRAP);
    COV_REJECT: cover property (read_reject ##[1:20] op_done);
endmodule : sfw_sequencer

// ==== testbench/sfw_host_model.sv ====
// Host-side link driver that frames flash commands for the sequencer
`timescale 1ns/1ps
module sfw_host_model (
    input wire logic clock,
    output logic serial_clock,
    output logic select_n,
    output logic [3:0] data_line_in
);
    // Idle link: serial clock parked low, select high
    initial begin
        serial_clock = 1'b0;
        select_n = 1'b1;
        data_line_in = 4'h5;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    // Two system clocks per phase so every level is sampled twice
    task automatic pulse(input logic [3:0] d);
        data_line_in = d;
        tick(2);
        serial_clock = 1'b1;
        tick(2);
        serial_clock = 1'b0;
    endtask : pulse
    // Select held low for the whole frame
    task automatic frame(input logic [7:0] b[$], input bit quad,
                         input int extra);
        logic [7:0] v;
        tick(1);
        select_n = 1'b0;
        foreach (b[i]) begin
            v = b[i];
            if (quad && i > 0) begin
                pulse(v[7:4]); // Nibbles after opcode
                pulse(v[3:0]);
            end else begin
                for (int k = 7; k >= 0; k--) begin
                    pulse({~v[k], ~v[k], ~v[k], v[k]});
                end
            end
        end
        // Extra pulses break the byte boundary on purpose
        repeat (extra) pulse(4'hA);
        tick(2);
        select_n = 1'b1; // After the last pulse, extra pulses included
        data_line_in = ~data_line_in;
        tick(2);
    endtask : frame
endmodule : sfw_host_model

// ==== testbench/testbench.sv ====
// Self-checking bench of the flash program, erase and wrap sequencer
`timescale 1ns/1ps
module testbench;
    import sfw_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic serial_clock, select_n, quad_enable_bit, rd_load, rd_advance;
    logic [3:0] data_line_in;
    logic [4:0] block_protect_bits;
    logic [7:0] buf_rd_idx, buf_rd_byte, o, w;
    logic [15:0] pg;
    logic [23:0] rd_start_addr, rd_addr;
    logic write_enable_latch, write_in_progress, wrap_disable_bit;
    logic [1:0] wrap_length_field;
    logic op_start, op_done, buf_rd_valid, status_read, read_reject;
    logic stat_seen = 1'b0;
    logic rej_seen = 1'b0;
    logic done_seen = 1'b0;
    sfw_op_s op_info, e;
    sfw_op_s notes[$];
    int miscompares = 0;
    int checked = 0;
    int seed = 27;
    int sp;
    always #12.5 clock = ~clock;
    sfw_host_model host (.clock(clock), .serial_clock(serial_clock),
        .select_n(select_n), .data_line_in(data_line_in));
    // Busy long enough to poll across several frames
    sfw_sequencer #(.PROG_CYCLES(400), .SECT_CYCLES(300),
        .BLK32_CYCLES(300), .BLK64_CYCLES(300)) dut (.clock(clock),
        .reset(reset), .serial_clock(serial_clock), .select_n(select_n),
        .data_line_in(data_line_in), .quad_enable_bit(quad_enable_bit),
        .block_protect_bits(block_protect_bits), .buf_rd_idx(buf_rd_idx),
        .rd_load(rd_load), .rd_advance(rd_advance),
        .rd_start_addr(rd_start_addr),
        .write_enable_latch(write_enable_latch),
        .write_in_progress(write_in_progress),
        .wrap_disable_bit(wrap_disable_bit),
        .wrap_length_field(wrap_length_field), .op_start(op_start),
        .op_done(op_done), .op_info(op_info), .buf_rd_byte(buf_rd_byte),
        .buf_rd_valid(buf_rd_valid), .status_read(status_read),
        .read_reject(read_reject), .rd_addr(rd_addr));
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] pat(input int k);
        return k[7:0] ^ {8{k[8]}};
    endfunction : pat
    function automatic int span(input sfw_op_e k);
        return k == OP_SECT ? SECT_BITS : k == OP_BLK32 ? BLK32_BITS :
            k == OP_BLK64 ? BLK64_BITS : PAGE_BITS;
    endfunction : span
    // Pulse catchers, cleared by the driver before each poll
    always @(posedge clock) begin
        if (status_read === 1'b1) stat_seen <= 1'b1;
        if (read_reject === 1'b1) rej_seen <= 1'b1;
        if (op_done === 1'b1) done_seen <= 1'b1;
    end
    // Each started cycle is matched against the oldest note
    always @(posedge clock) begin
        if (op_start === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected start", 32'h1, 32'h0);
            end else begin
                e = notes.pop_front();
                check("kind", op_info.kind, e.kind);
                check("region", op_info.addr >> span(e.kind),
                      e.addr >> span(e.kind));
                check("latch", write_enable_latch, 1'b0);
                check("busy", write_in_progress, 1'b1);
            end
        end
    end
    // Frames one command; refused ones must leave the device idle
    task automatic cmd(input logic [7:0] opc, input logic [23:0] a,
                       input int n, input int extra, input bit ok);
        logic [7:0] q[$];
        sfw_op_s x;
        q = '{opc, a[23:16], a[15:8], a[7:0]};
        for (int k = 0; k < n; k++) q.push_back(pat(k));
        x.addr = a;
        x.kind = opc == OPC_SECT ? OP_SECT : opc == OPC_BLK32 ? OP_BLK32 :
            opc == OPC_BLK64 ? OP_BLK64 : OP_PROG;
        if (ok) notes.push_back(x);
        host.frame(q, opc == OPC_QPROG, extra);
        if (!ok) check("idle", write_in_progress, 1'b0);
    endtask : cmd
    task automatic wait_idle;
        int n;
        n = 0;
        done_seen = 1'b0;
        while (write_in_progress !== 1'b0 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 1000) begin
            check("timeout", 32'h1, 32'h0);
            give_verdict();
        end
        #2;
        check("done pulse", done_seen, 1'b1);
    endtask : wait_idle
    task automatic bufchk(input logic [7:0] i, input logic [7:0] v,
                          input logic ok);
        buf_rd_idx = i;
        host.tick(2);
        check("valid", buf_rd_valid, ok);
        if (ok) check("byte", buf_rd_byte, v);
    endtask : bufchk
    // Loads a read address, steps it three times
    task automatic walk(input logic [23:0] a, input logic [23:0] x);
        rd_start_addr = a;
        rd_load = 1'b1;
        host.tick(1);
        rd_load = 1'b0;
        rd_advance = 1'b1;
        host.tick(3);
        rd_advance = 1'b0;
        host.tick(1);
        check("read addr", rd_addr, x);
    endtask : walk
    initial begin
        repeat (100000) @(posedge clock);
        check("timeout", 32'h1, 32'h0);
        give_verdict();
    end
    initial begin
        // Random levels where they must not matter yet
        quad_enable_bit = 1'($random(seed));
        block_protect_bits = {2'($random(seed)), 3'h0};
        buf_rd_idx = 8'($random(seed));
        rd_load = 1'b0;
        rd_advance = 1'b0;
        rd_start_addr = 24'h00_0000;
        repeat (4) @(posedge clock);
        #2 reset = 1'b0;
        check("wrap off", wrap_disable_bit, 1'b1);
        // Every section length, random page and offset
        for (int l = 0; l < 4; l++) begin
            pg = 16'($random(seed)) & 16'h0FFF;
            o = 8'($random(seed));
            w = {1'b0, l[1:0], 5'h00};
            sp = 8 << l;
            host.frame('{OPC_WRAP_SET, 8'h00, 8'h00, 8'h00, w}, 0, 0);
            check("wrap len", wrap_length_field, l[1:0]);
            walk({pg, o}, {pg, (o & 8'(~(sp - 1))) | ((o + 8'h03) &
                 8'(sp - 1))});
        end
        host.frame('{OPC_WRAP_SET, 8'h00, 8'h00, 8'h00, 8'h10}, 0, 0);
        walk({pg, 8'hFE}, {pg, 8'h00} + 24'h00_0101);
        cmd(OPC_PROG, {pg, 8'h00}, 2, 0, 0);
        host.frame('{OPC_WRITE_ENABLE_CMD}, 0, 0);
        check("latch set", write_enable_latch, 1'b1);
        cmd(OPC_PROG, {pg, 8'hFE}, 3, 0, 1);
        // Polls and refused commands while the cycle runs
        stat_seen = 1'b0;
        rej_seen = 1'b0;
        host.frame('{OPC_STAT_LO}, 0, 0);
        host.frame('{OPC_RD}, 0, 0);
        host.frame('{OPC_WRAP_SET, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 0);
        check("status", stat_seen, 1'b1);
        check("reject", rej_seen, 1'b1);
        check("wrap kept", wrap_disable_bit, 1'b1);
        check("still busy", write_in_progress, 1'b1);
        wait_idle();
        bufchk(8'hFE, 8'h00, 1'b1);
        bufchk(8'h00, 8'h02, 1'b1);
        bufchk(8'h01, 8'h00, 1'b0);
        host.frame('{OPC_WRITE_ENABLE_CMD}, 0, 0);
        cmd(OPC_PROG, {pg, 8'h00}, 258, 0, 1);
        wait_idle();
        bufchk(8'h00, 8'hFF, 1'b1);
        bufchk(8'h02, 8'h02, 1'b1);
        host.frame('{OPC_WRITE_ENABLE_CMD}, 0, 0);
        quad_enable_bit = 1'b0;
        cmd(OPC_QPROG, {pg, 8'h10}, 1, 0, 0);
        cmd(OPC_PROG, {pg, 8'h10}, 1, 4, 0);
        cmd(OPC_SECT, {pg, 8'h10}, 0, 2, 0);
        block_protect_bits = 5'h01;
        cmd(OPC_PROG, 24'h0F_0000, 1, 0, 0);
        cmd(OPC_SECT, 24'h0F_F000, 0, 0, 0);
        check("latch kept", write_enable_latch, 1'b1);
        block_protect_bits = 5'h00;
        quad_enable_bit = 1'b1;
        cmd(OPC_QPROG, {pg, 8'h20}, 1, 0, 1);
        wait_idle();
        bufchk(8'h20, 8'h00, 1'b1);
        for (int i = 0; i < 3; i++) begin
            host.frame('{OPC_WRITE_ENABLE_CMD}, 0, 0);
            cmd(i == 0 ? OPC_SECT : i == 1 ? OPC_BLK32 : OPC_BLK64,
                24'($random(seed)) & 24'h0F_FFFF, 0, 0, 1);
            wait_idle();
        end
        check("notes left", notes.size(), 32'h0);
        give_verdict();
    end
endmodule : testbench
